// ### rtl/plru_defines.svh
// Summary of operation
// - AND, OR, XOR combine two register or immediate operands into a register
// - zero_flag is 1 when the logic result is all zeros, else 0
// - Immediate operands in any notation arrive as one 32-bit value
// - Fill rotations shift one place per step, inserting zero
// - Circular rotations feed the outgoing bit back at the other end
// - A rotation repeats its step a count of 0 to 31 times
// - clear_range zeroes inputs, outputs, marks or registers in the span
// - clear_range resets timers and presets counters to zero
// - Marks only in the five windows, registers only 1 to 559
// - ctl_var_read copies variable to register, ctl_var_write the reverse
// - The busy mark is 1 from transfer start until its end
// - Access to a missing variable raises an error, no transfer
// - parity_check sets the mark 1 on even parity, 0 on odd
// - Serial write sends only when the line is idle, else drops
// - Serial read starts the receiver filling the chosen buffer
// - Only one serial read may be in progress at a time
// - Registers are 32 bits and actions use all 32 bits
// - An action runs only when its condition is 1
`ifndef PLRU_DEFINES_SVH
`define PLRU_DEFINES_SVH
`define PLRU_A_CTRL   12'h000
`define PLRU_A_OPA    12'h004
`define PLRU_A_OPB    12'h008
`define PLRU_A_DST    12'h00C
`define PLRU_A_PIDX   12'h010
`define PLRU_A_PDATA  12'h014
`define PLRU_F_COND   4
`define PLRU_F_AIMM   5
`define PLRU_F_BIMM   6
`define PLRU_F_MARK   16
`define PLRU_REG_MAX  32'h0000022F
`define PLRU_IO_MAX   32'h00000200
`define PLRU_TC_MAX   32'h00000100
`define PLRU_M1_LO    32'h00000001
`define PLRU_M1_HI    32'h000007FF
`define PLRU_M2_LO    32'h00000FA0
`define PLRU_M2_HI    32'h0000101F
`define PLRU_M3_LO    32'h00001194
`define PLRU_M3_HI    32'h000011D3
`define PLRU_M4_LO    32'h0000125C
`define PLRU_M4_HI    32'h0000135B
`define PLRU_M5_LO    32'h00001388
`define PLRU_M5_HI    32'h00001745
`define PLRU_ZF_MARK  13'h07D3
`endif

// ### rtl/plru_pkg.sv
`default_nettype none
package plru_pkg;
    typedef enum logic [3:0] {
        OP_AND = 4'h0, OP_OR = 4'h1, OP_XOR = 4'h2, OP_RLF = 4'h3,
        OP_RRF = 4'h4, OP_RLC = 4'h5, OP_RRC = 4'h6, OP_CLR = 4'h7,
        OP_VRD = 4'h8, OP_VWR = 4'h9, OP_PAR = 4'hA, OP_SWR = 4'hB,
        OP_SRD = 4'hC
    } plru_op_t;
    typedef enum logic [2:0] {
        RES_IN = 3'h0, RES_OUT = 3'h1, RES_MARK = 3'h2,
        RES_TMR = 3'h3, RES_CNT = 3'h4, RES_REG = 3'h5
    } plru_res_t;
    typedef enum logic [1:0] {S_IDLE, S_ROT, S_CLR, S_VAR} plru_st_t;
    typedef struct packed {
        plru_st_t  st;
        plru_op_t  op;
        logic [4:0]  cnt;
        logic [31:0] acc;
        logic [31:0] idx;
        logic [31:0] last;
        plru_res_t rtype;
        logic [31:0] opa;
        logic [31:0] opb;
        logic [31:0] dst;
        logic [9:0]  pidx;
        logic [31:0] prdata;
        logic        zflag;
        logic        err;
        logic        rx_busy;
        logic        mark_we;
        logic [12:0] mark_idx;
        logic        mark_val;
        logic        clr_we;
        plru_res_t clr_type;
        logic [12:0] clr_idx;
        logic        var_req;
        logic        var_wr;
        logic [31:0] var_id;
        logic [31:0] var_wdata;
        logic        tx_start;
        logic        rx_start;
        logic [3:0]  buf_idx;
    } plru_state_t;
endpackage
`default_nettype wire

// ### rtl/plru_rot_step.sv
`default_nettype none
module plru_rot_step (
    input  wire logic [31:0] din,
    input  wire logic        left,
    input  wire logic        circ,
    output logic      [31:0] dout
);
    // One rotation step; fill variants insert zero
    always_comb begin
        if (left) begin
            dout = {din[30:0], circ ? din[31] : 1'b0};
        end else begin
            dout = {circ ? din[0] : 1'b0, din[31:1]};
        end
    end
endmodule
`default_nettype wire

// ### rtl/plru_unit.sv
// The implementer's own choices: the APB slave port and the register addresses.
`include "plru_defines.svh"
`default_nettype none
module plru_unit (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             zero_flag,
    output logic             busy,
    output logic             error,
    output logic             mark_we,
    output logic      [12:0] mark_idx,
    output logic             mark_val,
    output logic             clr_we,
    output logic      [2:0]  clr_type,
    output logic      [12:0] clr_idx,
    output logic             var_req,
    output logic             var_wr,
    output logic      [31:0] var_id,
    output logic      [31:0] var_wdata,
    input  wire logic        var_ack,
    input  wire logic        var_err,
    input  wire logic [31:0] var_rdata,
    input  wire logic        ser_line_busy,
    output logic             ser_tx_start,
    output logic             ser_rx_start,
    output logic      [3:0]  buffer_index,
    input  wire logic        ser_rx_done
);
    plru_pkg::plru_state_t s;
    plru_pkg::plru_state_t n;
    logic [31:0] regs [0:559];
    logic        mem_we;
    logic [9:0]  mem_a;
    logic [31:0] mem_d;
    logic [31:0] aval;
    logic [31:0] bval;
    logic [31:0] lres;
    logic [31:0] stepped;
    logic        wr_acc;
    logic        start;
    logic        cond;
    plru_pkg::plru_op_t op_in;

    // Register index check
    function automatic logic reg_ok(input logic [31:0] v);
        return (v != 32'h0) && (v <= `PLRU_REG_MAX);
    endfunction

    // Span check per resource type, marks must sit in one window
    function automatic logic range_ok(input plru_pkg::plru_res_t t,
                                      input logic [31:0] f,
                                      input logic [31:0] l);
        logic ok;
        ok = (f != 32'h0) && (f <= l);
        case (t)
            plru_pkg::RES_IN, plru_pkg::RES_OUT: ok = ok && l <= `PLRU_IO_MAX;
            plru_pkg::RES_TMR, plru_pkg::RES_CNT: ok = ok && l <= `PLRU_TC_MAX;
            plru_pkg::RES_REG: ok = ok && l <= `PLRU_REG_MAX;
            plru_pkg::RES_MARK: begin
                ok = ok && ((f >= `PLRU_M1_LO && l <= `PLRU_M1_HI) ||
                            (f >= `PLRU_M2_LO && l <= `PLRU_M2_HI) ||
                            (f >= `PLRU_M3_LO && l <= `PLRU_M3_HI) ||
                            (f >= `PLRU_M4_LO && l <= `PLRU_M4_HI) ||
                            (f >= `PLRU_M5_LO && l <= `PLRU_M5_HI));
            end
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction

    // Bus handshake and action trigger
    assign pready  = 1'b1;
    assign wr_acc  = psel && penable && pwrite;
    assign start   = wr_acc && paddr == `PLRU_A_CTRL && s.st == plru_pkg::S_IDLE;
    assign cond    = pwdata[`PLRU_F_COND];
    assign op_in   = plru_pkg::plru_op_t'(pwdata[3:0]);
    assign pslverr = psel && penable && paddr > `PLRU_A_PDATA;

    // Operand fetch, immediates pass straight through
    assign aval = pwdata[`PLRU_F_AIMM] ? s.opa :
                  (reg_ok(s.opa) ? regs[s.opa[9:0]] : 32'h0);
    assign bval = pwdata[`PLRU_F_BIMM] ? s.opb :
                  (reg_ok(s.opb) ? regs[s.opb[9:0]] : 32'h0);

    // Full-width bitwise result
    always_comb begin
        case (op_in)
            plru_pkg::OP_AND: lres = aval & bval;
            plru_pkg::OP_OR:  lres = aval | bval;
            default:          lres = aval ^ bval;
        endcase
    end

    plru_rot_step u_step (
        .din  (s.acc),
        .left (s.op == plru_pkg::OP_RLF || s.op == plru_pkg::OP_RLC),
        .circ (s.op == plru_pkg::OP_RLC || s.op == plru_pkg::OP_RRC),
        .dout (stepped)
    );

    // Next-state logic for the action engine and the bus
    always_comb begin
        n = s;
        n.mark_we  = 1'b0;
        n.clr_we   = 1'b0;
        n.tx_start = 1'b0;
        n.rx_start = 1'b0;
        mem_we = 1'b0;
        mem_a  = 10'h000;
        mem_d  = 32'h0;
        if (ser_rx_done) begin
            n.rx_busy = 1'b0;
        end
        if (psel && !penable && !pwrite) begin
            case (paddr)
                `PLRU_A_CTRL:  n.prdata = {28'h0, s.rx_busy, s.zflag,
                                           s.err, s.st != plru_pkg::S_IDLE};
                `PLRU_A_OPA:   n.prdata = s.opa;
                `PLRU_A_OPB:   n.prdata = s.opb;
                `PLRU_A_DST:   n.prdata = s.dst;
                `PLRU_A_PIDX:  n.prdata = {22'h0, s.pidx};
                `PLRU_A_PDATA: n.prdata = regs[s.pidx];
                default:       n.prdata = 32'h0;
            endcase
        end
        if (wr_acc && s.st == plru_pkg::S_IDLE) begin
            case (paddr)
                `PLRU_A_OPA:  n.opa = pwdata;
                `PLRU_A_OPB:  n.opb = pwdata;
                `PLRU_A_DST:  n.dst = pwdata;
                `PLRU_A_PIDX: n.pidx = (pwdata[9:0] > 10'h22F) ? 10'h000
                                                               : pwdata[9:0];
                `PLRU_A_PDATA: begin
                    mem_we = 1'b1;
                    mem_a  = s.pidx;
                    mem_d  = pwdata;
                end
                default: ;
            endcase
        end
        case (s.st)
            plru_pkg::S_IDLE: begin
                if (start && cond) begin
                    n.err = 1'b0;
                    n.op  = op_in;
                    case (op_in)
                        plru_pkg::OP_AND, plru_pkg::OP_OR, plru_pkg::OP_XOR: begin
                            if (reg_ok(s.dst) &&
                                (pwdata[`PLRU_F_AIMM] || reg_ok(s.opa)) &&
                                (pwdata[`PLRU_F_BIMM] || reg_ok(s.opb))) begin
                                mem_we  = 1'b1;
                                mem_a   = s.dst[9:0];
                                mem_d   = lres;
                                n.zflag = (lres == 32'h0);
                            end else begin
                                n.err = 1'b1;
                            end
                        end
                        plru_pkg::OP_RLF, plru_pkg::OP_RRF,
                        plru_pkg::OP_RLC, plru_pkg::OP_RRC: begin
                            if (reg_ok(s.opa) && reg_ok(s.dst) &&
                                (pwdata[`PLRU_F_BIMM] || reg_ok(s.opb))) begin
                                n.acc = regs[s.opa[9:0]];
                                n.cnt = bval[4:0];
                                n.st  = plru_pkg::S_ROT;
                            end else begin
                                n.err = 1'b1;
                            end
                        end
                        plru_pkg::OP_CLR: begin
                            n.rtype = plru_pkg::plru_res_t'(pwdata[10:8]);
                            if (range_ok(plru_pkg::plru_res_t'(pwdata[10:8]),
                                         s.opa, s.opb)) begin
                                n.idx  = s.opa;
                                n.last = s.opb;
                                n.st   = plru_pkg::S_CLR;
                            end else begin
                                n.err = 1'b1;
                            end
                        end
                        plru_pkg::OP_VRD, plru_pkg::OP_VWR: begin
                            if (reg_ok(s.dst & 32'h3FF)) begin
                                n.var_req   = 1'b1;
                                n.var_wr    = (op_in == plru_pkg::OP_VWR);
                                n.var_id    = s.opb;
                                n.var_wdata = regs[s.dst[9:0]];
                                n.mark_we   = 1'b1;
                                n.mark_idx  = s.dst[`PLRU_F_MARK +: 13];
                                n.mark_val  = 1'b1;
                                n.st        = plru_pkg::S_VAR;
                            end else begin
                                n.err = 1'b1;
                            end
                        end
                        plru_pkg::OP_PAR: begin
                            if (reg_ok(s.opa)) begin
                                n.mark_we  = 1'b1;
                                n.mark_idx = s.dst[`PLRU_F_MARK +: 13];
                                n.mark_val = ~^regs[s.opa[9:0]];
                            end else begin
                                n.err = 1'b1;
                            end
                        end
                        plru_pkg::OP_SWR: begin
                            n.buf_idx  = s.opa[3:0];
                            n.tx_start = !ser_line_busy;
                        end
                        plru_pkg::OP_SRD: begin
                            if (s.rx_busy) begin
                                n.err = 1'b1;
                            end else begin
                                n.buf_idx  = s.opa[3:0];
                                n.rx_start = 1'b1;
                                n.rx_busy  = 1'b1;
                            end
                        end
                        default: n.err = 1'b1;
                    endcase
                end
            end
            plru_pkg::S_ROT: begin
                if (s.cnt == 5'h00) begin
                    mem_we = 1'b1;
                    mem_a  = s.dst[9:0];
                    mem_d  = s.acc;
                    n.st   = plru_pkg::S_IDLE;
                end else begin
                    n.acc = stepped;
                    n.cnt = s.cnt - 5'h01;
                end
            end
            plru_pkg::S_CLR: begin
                if (s.rtype == plru_pkg::RES_REG) begin
                    mem_we = 1'b1;
                    mem_a  = s.idx[9:0];
                    mem_d  = 32'h0;
                end else begin
                    n.clr_we   = 1'b1;
                    n.clr_type = s.rtype;
                    n.clr_idx  = s.idx[12:0];
                    if (s.rtype == plru_pkg::RES_MARK &&
                        s.idx[12:0] == `PLRU_ZF_MARK) begin
                        n.zflag = 1'b0;
                    end
                end
                n.idx = s.idx + 32'h1;
                if (s.idx == s.last) begin
                    n.st = plru_pkg::S_IDLE;
                end
            end
            plru_pkg::S_VAR: begin
                if (var_ack) begin
                    n.var_req  = 1'b0;
                    n.mark_we  = 1'b1;
                    n.mark_idx = s.dst[`PLRU_F_MARK +: 13];
                    n.mark_val = 1'b0;
                    n.st       = plru_pkg::S_IDLE;
                    if (var_err) begin
                        n.err = 1'b1;
                    end else if (!s.var_wr) begin
                        mem_we = 1'b1;
                        mem_a  = s.dst[9:0];
                        mem_d  = var_rdata;
                    end
                end
            end
            default: n.st = plru_pkg::S_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge clk) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    // General register file
    always_ff @(posedge clk) begin
        if (mem_we) begin
            regs[mem_a] <= mem_d;
        end
    end

    // Outputs straight from state
    assign prdata       = s.prdata;
    assign zero_flag    = s.zflag;
    assign busy         = s.st != plru_pkg::S_IDLE;
    assign error        = s.err;
    assign mark_we      = s.mark_we;
    assign mark_idx     = s.mark_idx;
    assign mark_val     = s.mark_val;
    assign clr_we       = s.clr_we;
    assign clr_type     = s.clr_type;
    assign clr_idx      = s.clr_idx;
    assign var_req      = s.var_req;
    assign var_wr       = s.var_wr;
    assign var_id       = s.var_id;
    assign var_wdata    = s.var_wdata;
    assign ser_tx_start = s.tx_start;
    assign ser_rx_start = s.rx_start;
    assign buffer_index = s.buf_idx;

    // Checks on the action engine
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_logic_go;
        start && cond && op_in <= plru_pkg::OP_XOR && reg_ok(s.dst) &&
        (pwdata[`PLRU_F_AIMM] || reg_ok(s.opa)) &&
        (pwdata[`PLRU_F_BIMM] || reg_ok(s.opb));
    endsequence
    sequence s_rot_zero;
        s.st == plru_pkg::S_ROT && s.cnt == 5'h00;
    endsequence

    property p_logic_wr;
        s_logic_go |-> mem_we && mem_a == s.dst[9:0] && mem_d == lres;
    endproperty
    a_logic_wr: assert property (p_logic_wr) else $error("logic result lost");

    property p_zflag;
        s_logic_go |=> zero_flag == ($past(lres) == 32'h0);
    endproperty
    a_zflag: assert property (p_zflag) else $error("zero flag wrong");

    property p_rot_done;
        s_rot_zero |-> mem_we && mem_d == s.acc ##1 !busy;
    endproperty
    a_rot_done: assert property (p_rot_done) else $error("rotation end bad");

    property p_par;
        start && cond && op_in == plru_pkg::OP_PAR && reg_ok(s.opa)
            |=> mark_we && mark_val == ~^$past(regs[s.opa[9:0]]);
    endproperty
    a_par: assert property (p_par) else $error("parity mark wrong");

    property p_var_busy;
        s.st == plru_pkg::S_VAR && !var_ack |=> !(mark_we && !mark_val);
    endproperty
    a_var_busy: assert property (p_var_busy) else $error("busy mark early");

    property p_tx_drop;
        start && cond && op_in == plru_pkg::OP_SWR && ser_line_busy
            |=> !ser_tx_start;
    endproperty
    a_tx_drop: assert property (p_tx_drop) else $error("sent on busy line");

    property p_one_rx;
        s.rx_busy && !ser_rx_done |=> !ser_rx_start;
    endproperty
    a_one_rx: assert property (p_one_rx) else $error("second read started");

    property p_skip;
        start && !cond |=> !busy && !mark_we && !clr_we && !ser_tx_start;
    endproperty
    a_skip: assert property (p_skip) else $error("skipped action acted");

    property p_clr_reg;
        s.st == plru_pkg::S_CLR && s.rtype == plru_pkg::RES_REG
            |-> mem_we && mem_d == 32'h0 && !clr_we;
    endproperty
    a_clr_reg: assert property (p_clr_reg) else $error("register not cleared");
endmodule
`default_nettype wire

// ### tb/plru_far_model.sv
`default_nettype none
module plru_far_model (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        slow,
    input  wire logic        var_req,
    input  wire logic        var_wr,
    input  wire logic [31:0] var_id,
    input  wire logic [31:0] var_wdata,
    input  wire logic        ser_rx_start,
    output logic             var_ack,
    output logic             var_err,
    output logic      [31:0] var_rdata,
    output logic      [31:0] last_wr,
    output logic             ser_rx_done
);
    timeunit 1ns;
    timeprecision 1ns;
    int wait_n;
    int rx_n;
    // Quiet outputs before the first edge
    initial begin
        var_ack = 1'b0;
        var_err = 1'b0;
        var_rdata = 32'h00000000;
        ser_rx_done = 1'b0;
    end
    // Variable store answers after a short or a long wait
    always @(posedge clk) begin
        var_ack <= 1'b0;
        var_err <= 1'b0;
        var_rdata <= ~var_rdata; // No valid data between answers
        wait_n <= (var_req && !var_ack) ? wait_n + 1 : 0;
        if (rst) begin
            wait_n <= 0;
        end else if (var_req && !var_ack && wait_n >= (slow ? 6 : 0)) begin
            var_ack <= 1'b1;
            var_err <= var_id > 32'h0000000F;
            var_rdata <= var_id ^ 32'hC3C30F0F;
            if (var_wr && var_id < 32'h00000010)
                last_wr <= var_wdata;
        end
    end
    // Receiver ends a read a while after it starts
    always @(posedge clk) begin
        if (rst || ser_rx_start)
            rx_n <= rst ? 0 : 60;
        else if (rx_n != 0)
            rx_n <= rx_n - 1;
        ser_rx_done <= (rx_n == 1) && !rst;
    end
endmodule
`default_nettype wire

// ### tb/tb_top.sv
`include "plru_defines.svh"
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic        ser_line_busy = 1'b0;
    logic        slow = 1'b0;
    logic [31:0] prdata, var_id, var_wdata, var_rdata, last_wr;
    logic        pready, pslverr, zero_flag, busy, error, mark_we, mark_val;
    logic        clr_we, var_req, var_wr, var_ack, var_err, last_err;
    logic        ser_tx_start, ser_rx_start, ser_rx_done;
    logic [12:0] mark_idx, clr_idx;
    logic [2:0]  clr_type;
    logic [3:0]  buffer_index, last_buf;
    logic [31:0] seed = 32'h0000EA35;
    logic [31:0] mk_q[$];
    int          failures = 0;
    int          n_checks = 0;
    int          n_clr[8];
    int          n_tx = 0;
    int          n_rx = 0;

    plru_unit u_plru_unit (.clk, .rst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .zero_flag, .busy, .error,
        .mark_we, .mark_idx, .mark_val, .clr_we, .clr_type, .clr_idx,
        .var_req, .var_wr, .var_id, .var_wdata, .var_ack, .var_err,
        .var_rdata, .ser_line_busy, .ser_tx_start, .ser_rx_start,
        .buffer_index, .ser_rx_done);
    plru_far_model u_plru_far_model (.clk, .rst, .slow, .var_req, .var_wr,
        .var_id, .var_wdata, .ser_rx_start, .var_ack, .var_err, .var_rdata,
        .last_wr, .ser_rx_done);

    // Clock of 100 ns
    always #50 clk = ~clk;
    // Records mark writes, clear pulses and serial starts
    always @(negedge clk) begin
        if (mark_we === 1'b1) mk_q.push_back({18'h0, mark_idx, mark_val});
        if (clr_we === 1'b1) n_clr[clr_type]++;
        if (ser_rx_start === 1'b1) n_rx++;
        if (ser_tx_start === 1'b1) begin
            n_tx++;
            last_buf = buffer_index;
        end
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [31:0] cw(input logic [3:0] op,
        input logic [2:0] rt, input logic ai, bi, cnd);
        return {21'h0, rt, 1'b0, bi, ai, cnd, op};
    endfunction
    function automatic logic [31:0] lg(input logic [3:0] op,
        input logic [31:0] a, b);
        if (op == plru_pkg::OP_AND) return a & b;
        return (op == plru_pkg::OP_OR) ? a | b : a ^ b;
    endfunction
    function automatic logic [31:0] rot(input logic [31:0] v,
        input logic [3:0] op, input int n);
        repeat (n) begin
            case (op)
                plru_pkg::OP_RLF: v = {v[30:0], 1'b0};
                plru_pkg::OP_RRF: v = {1'b0, v[31:1]};
                plru_pkg::OP_RLC: v = {v[30:0], v[31]};
                default: v = {v[0], v[31:1]};
            endcase
        end
        return v;
    endfunction

    task automatic chk(input logic [31:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    // One APB transfer, held until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask
    task automatic setr(input logic [31:0] i, v);
        wr(`PLRU_A_PIDX, i);
        wr(`PLRU_A_PDATA, v);
    endtask
    task automatic getr(input logic [31:0] i, output logic [31:0] v);
        wr(`PLRU_A_PIDX, i);
        apb(1'b0, `PLRU_A_PDATA, 32'h00000000, v);
    endtask
    // Loads operands, starts an action and waits until idle
    task automatic act(input logic [31:0] c, a, b, d);
        int n;
        wr(`PLRU_A_OPA, a);
        wr(`PLRU_A_OPB, b);
        wr(`PLRU_A_DST, d);
        wr(`PLRU_A_CTRL, c);
        repeat (3) @(posedge clk);
        for (n = 0; n < 400 && busy !== 1'b0; n++) @(posedge clk);
    endtask
    task automatic test_done();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Main sequence
    initial begin
        logic [31:0] a, b, v;
        logic [4:0] n;
        int k;
        logic [3:0] op;
        logic [2:0] rt_t[6] = '{3'h2, 3'h2, 3'h5, 3'h5, 3'h2, 3'h2};
        int lo_t[6] = '{2048, 4128, 560, 3, 4700, 5957};
        int hi_t[6] = '{2048, 4130, 560, 2, 4955, 5957};
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        for (k = 0; k < 9; k++) begin
            op = 4'(k % 3);
            a = (k == 0) ? 32'h00000092 : rnd();
            b = (k == 0) ? 32'h00000045 : (k == 2) ? a : rnd();
            setr(32'h000000C8, a);
            setr(32'h000000C9, b);
            act(cw(op, 3'h0, k > 2, 1'b0, 1'b1), (k > 2) ? a : 32'h000000C8,
                32'h000000C9, 32'h0000022F);
            getr(32'h0000022F, v);
            chk(v, lg(op, a, b));
            chk({31'h0, zero_flag}, {31'h0, lg(op, a, b) == 0});
        end
        act(cw(4'h1, 3'h0, 1'b1, 1'b1, 1'b0), rnd(), rnd(), 32'h0000022F);
        getr(32'h0000022F, v);
        chk(v, lg(op, a, b));
        for (k = 0; k < 12; k++) begin
            op = 4'(3 + k % 4);
            a = (k == 2) ? 32'h30CC46D4 : rnd();
            v = rnd();
            n = (k == 0) ? 5'h00 : (k == 1) ? 5'h1F : (k == 2) ? 5'h04 : v[4:0];
            setr(32'h00000001, a);
            setr(32'h00000003, {27'h0, n});
            act(cw(op, 3'h0, 1'b0, k[0], 1'b1), 32'h00000001,
                k[0] ? {27'h0, n} : 32'h00000003, 32'h00000002);
            getr(32'h00000002, v);
            chk(v, rot(a, op, n));
        end
        for (k = 0; k < 5; k++) begin
            n_clr[k] = 0;
            act(cw(4'h7, 3'(k), 1'b1, 1'b1, 1'b1), 32'h5, 32'h7, 32'h0);
            chk(n_clr[k], 3);
        end
        for (k = 10; k < 15; k++) setr(k, 32'hFFFF0000 + k);
        act(cw(4'h7, 3'h5, 1'b1, 1'b1, 1'b1), 32'hB, 32'hD, 32'h0);
        for (k = 10; k < 15; k++) begin
            getr(k, v);
            chk(v, (k > 10 && k < 14) ? 32'h0 : 32'hFFFF0000 + k);
        end
        for (k = 0; k < 6; k++) begin
            act(cw(4'h7, rt_t[k], 1'b1, 1'b1, 1'b1), lo_t[k], hi_t[k], 0);
            chk({31'h0, error}, {31'h0, k < 4});
        end
        slow = 1'b1;
        mk_q.delete();
        act(cw(4'h8, 3'h0, 1'b1, 1'b1, 1'b1), 0, 32'h5, 32'h00C80004);
        getr(32'h00000004, v);
        chk(v, 32'h5 ^ 32'hC3C30F0F);
        chk(mk_q.size(), 2);
        chk(mk_q[0], {18'h0, 13'h00C8, 1'b1});
        chk(mk_q[1], {18'h0, 13'h00C8, 1'b0});
        slow = 1'b0;
        a = rnd();
        setr(32'h00000006, a);
        act(cw(4'h9, 3'h0, 1'b1, 1'b1, 1'b1), 0, 32'h7, 32'h00C80006);
        chk(last_wr, a);
        act(cw(4'h8, 3'h0, 1'b1, 1'b1, 1'b1), 0, 32'h40, 32'h00C80004);
        chk({31'h0, error}, 32'h1);
        for (k = 0; k < 4; k++) begin
            a = (k == 0) ? 32'h0 : rnd();
            setr(32'h00000008, a);
            mk_q.delete();
            act(cw(4'hA, 3'h0, 1'b1, 1'b1, 1'b1), 8, 0, 32'h00DE0000);
            chk(mk_q[0], {18'h0, 13'h00DE, ~^a});
        end
        ser_line_busy <= 1'b1;
        act(cw(4'hB, 3'h0, 1'b1, 1'b1, 1'b1), 5, 0, 0);
        chk(n_tx, 0);
        ser_line_busy <= 1'b0;
        act(cw(4'hB, 3'h0, 1'b1, 1'b1, 1'b1), 5, 0, 0);
        chk({n_tx[27:0], last_buf}, 32'h15);
        act(cw(4'hC, 3'h0, 1'b1, 1'b1, 1'b1), 9, 0, 0);
        act(cw(4'hC, 3'h0, 1'b1, 1'b1, 1'b1), 10, 0, 0);
        chk({n_rx[30:0], error}, 32'h3);
        repeat (80) @(posedge clk);
        act(cw(4'hC, 3'h0, 1'b1, 1'b1, 1'b1), 11, 0, 0);
        chk({n_rx[30:0], error}, 32'h4);
        apb(1'b0, 12'h018, 32'h0, v);
        chk({31'h0, last_err}, 32'h1);
        test_done();
    end
    // Cuts a hang short
    initial begin
        #(100 * 40000);
        failures++;
        test_done();
    end
endmodule
`default_nettype wire
